// *** src/jmd_map.vh ***
// constants for the jump and move decode block
`ifndef JMD_MAP_VH
`define JMD_MAP_VH
`define JMD_JMP_OP_MSB 11
`define JMD_JMP_OP_LSB 9
`define JMD_JMP_OP 3'h5
`define JMD_STORE_OP 7'h01
`define JMD_MODE_LIT_OP 8'h05
`define JMD_PC_W 12
`define JMD_TARGET_W 9
`define JMD_FR_W 5
`define JMD_MODE_W 5
`define JMD_LIT_W 4
`define JMD_STATUS_PAGE_LSB 5
`define JMD_STATUS_RESET 8'h00
`define JMD_MODE_RESET 5'h1F
`define JMD_PC_RESET 12'hFFF
`define JMD_JMP_CYC_COMPAT 2
`define JMD_JMP_CYC_TURBO 3
`endif

// *** src/jmd_target.v ***
// jump target builder: page bits above the nine-bit instruction field
`timescale 1ns/100ps
module jmd_target (
    input wire [11:0] instr,
    input wire [7:0] status,
    output wire [11:0] target
);
`include "jmd_map.vh"
    // the page must already sit in status before the jump is decoded
    assign target = {status[`JMD_STATUS_PAGE_LSB+2:`JMD_STATUS_PAGE_LSB],
                     instr[`JMD_TARGET_W-1:0]};
endmodule

// *** src/jmd_decode.v ***
// decode and execute of jump, store-accumulator and mode-literal instructions
`timescale 1ns/100ps
module jmd_decode (
    input wire clk,
    input wire reset_n,
    input wire instr_valid,
    input wire [11:0] instr,
    input wire [7:0] accum,
    input wire [7:0] status,
    input wire turbo_mode,
    input wire wide_variant,
    input wire mode_from_acc,
    output reg busy,
    output reg [11:0] pc,
    output reg pc_load,
    output reg fr_we,
    output reg [4:0] fr_addr,
    output reg [7:0] fr_wdata,
    output reg [4:0] mode,
    output reg [4:0] port_ctrl_sel,
    output reg status_we
);
`include "jmd_map.vh"
    // limitations: nothing is queued; a word offered while a jump still runs
    // is dropped and the core has to present it again
    // the accumulator-to-mode move comes on its own strobe, not as a decoded
    // word, so it acts even while a jump is running

    // one-hot sequencer states; only idle accepts an instruction word
    localparam S_IDLE = 3'h1;
    localparam S_JMP = 3'h2;
    localparam S_DONE = 3'h4;

    // sequencer state with its next value
    reg [2:0] state_reg;
    reg [2:0] state_next;

    // next values of the registered outputs
    reg busy_next;
    reg [11:0] pc_next;
    reg pc_load_next;
    reg fr_we_next;
    reg [4:0] fr_addr_next;
    reg [7:0] fr_wdata_next;
    wire [4:0] mode_next;
    wire [4:0] sel_next;

    // decode results for the word on the instruction bus
    wire [11:0] target;
    wire is_jmp;
    wire is_store;
    wire is_lit;
    wire idle;
    wire take;
    wire take_jmp;
    wire take_store;
    wire take_lit;

    // operand views
    wire [4:0] acc_mode;
    wire [3:0] lit_value;

    // page bits and jump field are merged apart from the sequencer
    // the page bits must already sit in status when the jump is decoded
    jmd_target jmd_target_i (
        .instr(instr),
        .status(status),
        .target(target)
    );

    // opcode match on the fixed high bits of each format
    assign is_jmp = instr[`JMD_JMP_OP_MSB:`JMD_JMP_OP_LSB] == `JMD_JMP_OP;
    assign is_store = instr[11:5] == `JMD_STORE_OP;
    assign is_lit = instr[11:4] == `JMD_MODE_LIT_OP;

    // acceptance: a word counts only in idle, so the jump's extra cycles
    // swallow whatever the core offers meanwhile
    assign idle = state_reg == S_IDLE;
    assign take = instr_valid && idle;
    assign take_jmp = take && is_jmp;
    assign take_store = take && is_store;
    assign take_lit = take && is_lit;

    // narrow parts never see accumulator bit 4 in the mode register
    assign acc_mode = {wide_variant & accum[4], accum[3:0]};
    assign lit_value = instr[`JMD_LIT_W-1:0];

    // jump sequencer: the accept cycle is the first jump cycle, so compatible
    // mode adds one busy cycle and turbo mode adds two
    always @* begin
        state_next = state_reg;
        busy_next = busy;
        pc_next = pc;
        pc_load_next = 1'h0;
        case (state_reg)
            S_IDLE: begin
                if (take_jmp) begin
                    pc_next = target;
                    pc_load_next = 1'h1;
                    busy_next = 1'h1;
                    // turbo passes through S_JMP for its second cycle, so S_DONE is its third
                    if (turbo_mode) begin
                        state_next = S_JMP;
                    end else begin
                        state_next = S_DONE;
                    end
                end
            end
            S_JMP: begin
                // turbo only: one more busy cycle
                state_next = S_DONE;
            end
            S_DONE: begin
                // busy drops here, so the next word is taken at the following edge
                busy_next = 1'h0;
                state_next = S_IDLE;
            end
            default: begin
                // an illegal code falls back to idle with busy cleared
                busy_next = 1'h0;
                state_next = S_IDLE;
            end
        endcase
    end

    // sequencer state and busy flag
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= S_IDLE;
            busy <= 1'h0;
        end else begin
            state_reg <= state_next;
            busy <= busy_next;
        end
    end

    // program counter holds its value between jumps; load strobe is one cycle
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pc <= `JMD_PC_RESET;
            pc_load <= 1'h0;
        end else begin
            pc <= pc_next;
            pc_load <= pc_load_next;
        end
    end

    // store path: address and data stay after the write pulse so that a
    // slow file register may sample them late
    always @* begin
        fr_we_next = take_store;
        fr_addr_next = fr_addr;
        fr_wdata_next = fr_wdata;
        if (take_store) begin
            fr_addr_next = instr[`JMD_FR_W-1:0];
            fr_wdata_next = accum;
        end
    end

    // mode register next value, one slice per bit; the accumulator move wins
    // over a literal in the same cycle since it stands for its own instruction
    genvar gi;
    generate
        for (gi = 0; gi < `JMD_MODE_W; gi = gi + 1) begin : g_mode
            if (gi < `JMD_LIT_W) begin : g_low
                // low bits take either source
                assign mode_next[gi] = mode_from_acc ? acc_mode[gi] :
                                       take_lit ? lit_value[gi] : mode[gi];
                // the selector copies the low bits unchanged
                assign sel_next[gi] = mode[gi];
            end else begin : g_high
                // the literal cannot reach bit 4; only the accumulator move sets it
                assign mode_next[gi] = mode_from_acc ? acc_mode[gi] : mode[gi];
                // narrow parts decode only four selector bits
                assign sel_next[gi] = wide_variant & mode[gi];
            end
        end
    endgenerate

    // store registers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fr_we <= 1'h0;
            fr_addr <= 5'h00;
            fr_wdata <= 8'h00;
        end else begin
            fr_we <= fr_we_next;
            fr_addr <= fr_addr_next;
            fr_wdata <= fr_wdata_next;
        end
    end

    // mode and selector; the selector trails the mode register by one cycle
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode <= `JMD_MODE_RESET;
            port_ctrl_sel <= `JMD_MODE_RESET;
        end else begin
            mode <= mode_next;
            port_ctrl_sel <= sel_next;
        end
    end

    // none of these instructions touches a status flag
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_we <= 1'h0;
        end else begin
            status_we <= 1'h0;
        end
    end
endmodule

// *** tb/jmd_decode_properties.sv ***
// assertions for the jump and move decode block
`timescale 1ns/100ps
module jmd_decode_properties (
    input clk, reset_n, instr_valid, turbo_mode, wide_variant, mode_from_acc, busy,
    input pc_load, fr_we, status_we, input [11:0] instr, pc, input [7:0] accum, status,
    input [7:0] fr_wdata, input [4:0] fr_addr, mode, port_ctrl_sel
);
    reg up, pw;
    reg [11:0] pi;
    reg [7:0] pa;
    reg [4:0] pm;
    reg [2:0] ps;
    wire tk = instr_valid && !busy;
    wire jp = tk && instr[11:9] == 3'h5;
    wire st = tk && instr[11:5] == 7'h01;
    wire lt = tk && instr[11:4] == 8'h05 && !mode_from_acc;
    wire ac = tk && mode_from_acc;
    // busy covers every refused cycle; up marks one edge passed since reset
    always @(posedge clk or negedge reset_n)
        if (!reset_n) up <= 1'h0;
        else up <= 1'h1;
    // last-cycle copies keep the properties short
    always @(posedge clk)
        {pi, pa, ps, pw, pm} <= {instr, accum, status[7:5], wide_variant, mode};
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_PC: assert property (jp |=> pc_load && pc == {ps, pi[8:0]}) else $error("jump target");
    AST_CMP: assert property (jp && !turbo_mode |=> busy ##1 !busy) else $error("short jump");
    AST_TRB: assert property (jp && turbo_mode |=> busy [*2] ##1 !busy) else $error("long jump");
    AST_STO: assert property (st |=> fr_we && {fr_addr, fr_wdata} == {pi[4:0], pa})
        else $error("store");
    AST_LIT: assert property (lt |=> mode == {pm[4], pi[3:0]}) else $error("literal");
    AST_ACC: assert property (ac |=> mode == (pa[4:0] & {pw, 4'hF})) else $error("acc");
    AST_SEL: assert property (up |-> port_ctrl_sel == (pm & {pw, 4'hF})) else $error("sel");
    AST_FLG: assert property (!status_we) else $error("flag write");
    cover property (jp && turbo_mode);
    cover property (jp && !turbo_mode);
    cover property (st ##1 st);
    cover property (ac ##1 lt);
endmodule
bind jmd_decode jmd_decode_properties jmd_decode_properties_i (
    .clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .turbo_mode(turbo_mode),
    .wide_variant(wide_variant), .mode_from_acc(mode_from_acc), .busy(busy),
    .pc_load(pc_load), .fr_we(fr_we), .status_we(status_we), .instr(instr), .pc(pc),
    .accum(accum), .status(status), .fr_wdata(fr_wdata), .fr_addr(fr_addr), .mode(mode),
    .port_ctrl_sel(port_ctrl_sel)
);

// *** tb/jmd_decode_tb.sv ***
// self-checking bench for the jump and move decode block
`timescale 1ns/100ps
module jmd_decode_tb;
    reg clk, reset_n, instr_valid, turbo_mode, wide_variant, mode_from_acc;
    reg [11:0] instr;
    reg [7:0] accum, status;
    wire busy, pc_load, fr_we, status_we;
    wire [11:0] pc;
    wire [7:0] fr_wdata;
    wire [4:0] fr_addr, mode, port_ctrl_sel;
    integer miscompares = 0, total_checks = 0, n;
    jmd_decode jmd_decode_i (
        .clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
        .accum(accum), .status(status), .turbo_mode(turbo_mode),
        .wide_variant(wide_variant), .mode_from_acc(mode_from_acc), .busy(busy), .pc(pc),
        .pc_load(pc_load), .fr_we(fr_we), .fr_addr(fr_addr), .fr_wdata(fr_wdata),
        .mode(mode), .port_ctrl_sel(port_ctrl_sel), .status_we(status_we)
    );
    always #2 clk = ~clk;
    task chk(input [15:0] seen, exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // valid stays up so that calls may follow each other cycle by cycle
    task op(input [11:0] i, input [7:0] a, input m);
        {instr_valid, instr, accum, mode_from_acc} = {1'h1, i, a, m};
        @(negedge clk);
    endtask
    task jump_case(input t);
        {turbo_mode, status} = {t, t ? 8'hE0 : 8'h60};
        op(12'hB5A, 8'h00, 1'h0);
        chk({pc_load, pc}, {1'h1, t ? 12'hF5A : 12'h75A}, "pc");
        instr = 12'h03F; // a store offered during the jump must be dropped
        for (n = 0; busy === 1'h1 && n < 8; n++) @(negedge clk);
        chk(n, t ? 2 : 1, "busy cycles");
        chk(fr_we, 0, "dropped store");
        if (n == 8) disable scenarios;
        @(negedge clk);
        chk(fr_we, 1, "store after jump");
        instr_valid = 1'h0;
        @(negedge clk);
    endtask
    task store_case;
        op(12'h03F, 8'h3C, 1'h0);
        chk({fr_we, fr_addr, fr_wdata}, 16'h3F3C, "store 1F");
        op(12'h021, 8'hC3, 1'h0);
        chk({fr_we, fr_addr, fr_wdata}, 16'h21C3, "store 01");
        instr_valid = 1'h0;
        @(negedge clk);
        chk({fr_we, status_we}, 0, "store pulse end");
    endtask
    task mode_case(input w);
        wide_variant = w;
        @(negedge clk);
        chk(port_ctrl_sel, w ? 5'h1F : 5'h05, "selector width");
        op(12'h000, 8'h1A, 1'h1);
        chk(mode, w ? 5'h1A : 5'h0A, "acc mode");
        op(12'h055, 8'h00, 1'h0);
        chk(mode, w ? 5'h15 : 5'h05, "literal mode");
        {instr_valid, mode_from_acc} = 2'h0;
        @(negedge clk);
        chk(port_ctrl_sel, w ? 5'h15 : 5'h05, "selector");
    endtask
    initial begin
        {clk, reset_n, instr_valid, turbo_mode, wide_variant, mode_from_acc} = 6'h0;
        {instr, accum, status} = 28'h0;
        repeat (3) @(negedge clk);
        reset_n = 1'h1;
        @(negedge clk);
        begin : scenarios
            jump_case(1'h0);
            jump_case(1'h1);
            store_case;
            mode_case(1'h1);
            mode_case(1'h0);
        end
        end_of_test;
    end
endmodule
